// ### debug_exc_pkg.sv
package debug_exc_pkg;

   // ----------------------------------------------------------------
   // Register numbers on the system coprocessor port
   // ----------------------------------------------------------------
   localparam logic [4:0]  REG_DEBUG_CONTROL_STATUS = 5'h10;
   localparam logic [4:0]  REG_DEBUG_RETURN_ADDRESS = 5'h11;

   // ----------------------------------------------------------------
   // Field positions in debug_control_status
   // ----------------------------------------------------------------
   localparam int BIT_BRANCH_DELAY  = 31;
   localparam int BIT_DEBUG_MODE    = 30;
   localparam int BIT_COINC_NMI     = 14;
   localparam int BIT_COINC_OTHER   = 12;
   localparam int BIT_TLB_EXC       = 11;
   localparam int BIT_BUS_ERROR     = 10;
   localparam int BIT_SINGLE_STEP   = 8;
   localparam int BIT_BREAKPOINT    = 1;
   localparam int BIT_STEP_EXC      = 0;

   // ----------------------------------------------------------------
   // Vectors and reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] DEBUG_VECTOR       = 32'hBFC0_0200;
   localparam logic [31:0] RETURN_ADDR_RESET  = 32'h0000_0000;

   // Debug exception request from the pipeline
   typedef struct packed {
      logic        step;         // Single-step candidate instruction
      logic        brk;          // Soft debug break instruction executed
      logic        in_delay;     // Triggering instruction in delay slot
      logic        is_branch;    // Triggering instruction is a branch
      logic [31:0] pc;           // Address of triggering instruction
      logic [31:0] branch_pc;    // Address of preceding branch
      logic        nmi;          // Coincident non-maskable interrupt
      logic        other_exc;    // Coincident ordinary exception
   } debug_req_t;

   // Register port access
   typedef struct packed {
      logic        wr;
      logic [4:0]  addr;
      logic [31:0] wdata;
   } reg_access_t;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_HANDLER,
      ST_EXEMPT
   } debug_state_t;

endpackage : debug_exc_pkg

// ### debug_exception_unit.sv
`timescale 1ns/10ps
module debug_exception_unit (
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_sys_rst,
   input  wire debug_exc_pkg::debug_req_t  i_req,
   input  wire logic                       i_retire,
   input  wire logic                       i_retire_in_delay,
   input  wire logic                       i_retire_is_branch,
   input  wire logic                       i_return_instr,
   input  wire logic                       i_nmi_req,
   input  wire logic                       i_ls_tlb_exc,
   input  wire logic                       i_ls_bus_err,
   input  wire logic                       i_cache_autolock,
   input  wire debug_exc_pkg::reg_access_t i_reg,
   output logic                            o_redirect,
   output logic [31:0]                     o_redirect_pc,
   output logic                            o_set_status_ku_ie,
   output logic                            o_ordinary_exc_update,
   output logic                            o_nmi_take,
   output logic                            o_ls_squash,
   output logic                            o_autolock_en,
   output logic                            o_step_active,
   output logic [31:0]                     o_reg_rdata
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   debug_exc_pkg::debug_state_t state_reg;
   logic [31:0] return_addr_reg;
   logic        branch_delay_reg;
   logic        debug_mode_reg;
   logic        coinc_nmi_reg;
   logic        coinc_other_reg;
   logic        tlb_exc_reg;
   logic        bus_error_reg;
   logic        step_enable_reg;
   logic        breakpoint_reg;
   logic        step_exc_reg;
   logic        nmi_pending_reg;
   logic        exempt_branch_reg;

   logic        step_take;
   logic        brk_take;
   logic        enter;
   logic        ctl_wr;
   logic        ret_wr;
   logic        do_return;

   function automatic logic [31:0] pack_ctl(input logic bd, input logic dm, input logic ni,
                                            input logic oe, input logic tl, input logic bs,
                                            input logic ss, input logic bp, input logic st);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[debug_exc_pkg::BIT_BRANCH_DELAY] = bd;
      v[debug_exc_pkg::BIT_DEBUG_MODE]   = dm;
      v[debug_exc_pkg::BIT_COINC_NMI]    = ni;
      v[debug_exc_pkg::BIT_COINC_OTHER]  = oe;
      v[debug_exc_pkg::BIT_TLB_EXC]      = tl;
      v[debug_exc_pkg::BIT_BUS_ERROR]    = bs;
      v[debug_exc_pkg::BIT_SINGLE_STEP]  = ss;
      v[debug_exc_pkg::BIT_BREAKPOINT]   = bp;
      v[debug_exc_pkg::BIT_STEP_EXC]     = st;
      return v;
   endfunction : pack_ctl

   // ----------------------------------------------------------------
   // Exception selection
   // ----------------------------------------------------------------
   // Step masked in handler, in delay slot and in the post-return exemption
   assign step_take = i_req.step && step_enable_reg && !debug_mode_reg
                      && !i_req.in_delay && (state_reg == debug_exc_pkg::ST_RUN);
   assign brk_take  = i_req.brk && !step_take && !debug_mode_reg;
   assign enter     = step_take || brk_take;
   assign do_return = i_return_instr && debug_mode_reg;
   assign ctl_wr    = i_reg.wr && (i_reg.addr == debug_exc_pkg::REG_DEBUG_CONTROL_STATUS);
   assign ret_wr    = i_reg.wr && (i_reg.addr == debug_exc_pkg::REG_DEBUG_RETURN_ADDRESS);

   // ----------------------------------------------------------------
   // Mode state machine
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         state_reg         <= debug_exc_pkg::ST_RUN;
         exempt_branch_reg <= 1'b0;
      end else begin
         case (state_reg)
            debug_exc_pkg::ST_RUN: begin
               if (enter) begin
                  state_reg <= debug_exc_pkg::ST_HANDLER;
               end
            end
            debug_exc_pkg::ST_HANDLER: begin
               if (do_return) begin
                  state_reg         <= debug_exc_pkg::ST_EXEMPT;
                  exempt_branch_reg <= 1'b0;
               end
            end
            debug_exc_pkg::ST_EXEMPT: begin
               // Breakpoint may still hit during the exemption
               if (enter) begin
                  state_reg         <= debug_exc_pkg::ST_HANDLER;
                  exempt_branch_reg <= 1'b0;
               end else if (i_retire) begin
                  if (i_retire_is_branch && !exempt_branch_reg) begin
                     exempt_branch_reg <= 1'b1;
                  end else begin
                     state_reg         <= debug_exc_pkg::ST_RUN;
                     exempt_branch_reg <= 1'b0;
                  end
               end
            end
            default: begin
               state_reg <= debug_exc_pkg::ST_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Debug mode and return address
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         debug_mode_reg <= 1'b0;
      end else if (enter) begin
         debug_mode_reg <= 1'b1;
      end else if (do_return) begin
         debug_mode_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         return_addr_reg <= debug_exc_pkg::RETURN_ADDR_RESET;
      end else if (enter) begin
         return_addr_reg <= i_req.in_delay ? i_req.branch_pc : i_req.pc;
      end else if (ret_wr) begin
         return_addr_reg <= i_reg.wdata;
      end
   end

   // ----------------------------------------------------------------
   // Debug control flags
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         branch_delay_reg <= 1'b0;
         coinc_nmi_reg    <= 1'b0;
         coinc_other_reg  <= 1'b0;
         breakpoint_reg   <= 1'b0;
         step_exc_reg     <= 1'b0;
      end else if (enter) begin
         branch_delay_reg <= i_req.in_delay;
         coinc_nmi_reg    <= i_req.nmi;
         coinc_other_reg  <= i_req.other_exc && !i_req.nmi;
         breakpoint_reg   <= brk_take;
         step_exc_reg     <= step_take;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         tlb_exc_reg <= 1'b0;
      end else if (debug_mode_reg && i_ls_tlb_exc) begin
         tlb_exc_reg <= 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         bus_error_reg <= 1'b0;
      end else if (debug_mode_reg && i_ls_bus_err) begin
         bus_error_reg <= 1'b1;
      end else if (ctl_wr && !i_reg.wdata[debug_exc_pkg::BIT_BUS_ERROR]) begin
         bus_error_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         step_enable_reg <= 1'b0;
      end else if (ctl_wr) begin
         step_enable_reg <= i_reg.wdata[debug_exc_pkg::BIT_SINGLE_STEP];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         nmi_pending_reg <= 1'b0;
      end else if (debug_mode_reg && i_nmi_req && !do_return) begin
         nmi_pending_reg <= 1'b1;
      end else if (!debug_mode_reg) begin
         nmi_pending_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_redirect            <= 1'b0;
         o_redirect_pc         <= debug_exc_pkg::RETURN_ADDR_RESET;
         o_set_status_ku_ie    <= 1'b0;
         o_ordinary_exc_update <= 1'b0;
         o_nmi_take            <= 1'b0;
      end else begin
         o_redirect            <= enter || do_return;
         o_redirect_pc         <= enter ? debug_exc_pkg::DEBUG_VECTOR
                                        : return_addr_reg;
         o_set_status_ku_ie    <= do_return;
         // Ordinary registers load only for the coincident exception
         o_ordinary_exc_update <= enter && (i_req.nmi || i_req.other_exc);
         o_nmi_take            <= do_return && (nmi_pending_reg || i_nmi_req);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_ls_squash   <= 1'b0;
         o_autolock_en <= 1'b0;
         o_step_active <= 1'b0;
      end else begin
         o_ls_squash   <= debug_mode_reg && i_ls_tlb_exc;
         o_autolock_en <= i_cache_autolock && !(debug_mode_reg || enter) && !do_return ? 1'b1
                          : (i_cache_autolock && do_return);
         o_step_active <= step_enable_reg && !debug_mode_reg;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_reg_rdata <= 32'h0000_0000;
      end else begin
         case (i_reg.addr)
            debug_exc_pkg::REG_DEBUG_CONTROL_STATUS: begin
               o_reg_rdata <= pack_ctl(branch_delay_reg, debug_mode_reg, coinc_nmi_reg,
                                       coinc_other_reg, tlb_exc_reg, bus_error_reg,
                                       step_enable_reg, breakpoint_reg, step_exc_reg);
            end
            debug_exc_pkg::REG_DEBUG_RETURN_ADDRESS: begin
               o_reg_rdata <= return_addr_reg;
            end
            default: begin
               o_reg_rdata <= 32'h0000_0000;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_ENTRY_VECTOR: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      enter |=> o_redirect && o_redirect_pc == debug_exc_pkg::DEBUG_VECTOR)
      else $error("Entry did not redirect to debug vector");
   AST_RETURN_ADDR: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      enter |=> return_addr_reg == $past(i_req.in_delay ? i_req.branch_pc : i_req.pc))
      else $error("Return address not captured");
   AST_MODE_SET: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      enter |=> debug_mode_reg ##1 !o_step_active)
      else $error("Debug mode not set on entry");
   AST_RETURN: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      do_return |=> !debug_mode_reg && o_set_status_ku_ie && o_redirect_pc == $past(return_addr_reg))
      else $error("Return sequence wrong");
   AST_STEP_OVER_BRK: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      enter |=> breakpoint_reg != step_exc_reg)
      else $error("Step and breakpoint together");
   AST_NO_REENTRY: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      debug_mode_reg && !do_return |=> !o_redirect)
      else $error("Debug exception taken in handler");
   AST_ONE_COINC: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      !(coinc_nmi_reg && coinc_other_reg))
      else $error("Both coincidence flags set");
   AST_BUS_ERR: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      debug_mode_reg && i_ls_bus_err |=> bus_error_reg)
      else $error("Bus error flag not set");
   AST_AUTOLOCK: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      debug_mode_reg && $past(debug_mode_reg) |-> !o_autolock_en)
      else $error("Auto-lock active in handler");
   AST_EXEMPT: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      do_return |=> state_reg == debug_exc_pkg::ST_EXEMPT && !step_take)
      else $error("Step raised on return target");
   COV_STEP: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) step_take);
   COV_BRK_DELAY: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) brk_take && i_req.in_delay);
   COV_NMI_HELD: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) do_return && nmi_pending_reg);

endmodule : debug_exception_unit

// ### pipeline_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Pipeline side: instruction requests and load/store events
// ------------------------------------------------------------
module pipeline_model (
   input  wire logic                 i_clk_sys,
   output debug_exc_pkg::debug_req_t o_req,
   output logic                      o_retire,
   output logic                      o_retire_in_delay,
   output logic                      o_retire_is_branch,
   output logic [3:0]                o_event
);
   initial begin
      o_req = '0;
      o_retire = 1'h0;
      o_retire_in_delay = 1'h0;
      o_retire_is_branch = 1'h0;
      o_event = 4'h0;
   end

   // One instruction for one cycle, then stale address lines flip
   task issue(input debug_exc_pkg::debug_req_t r);
      @(negedge i_clk_sys);
      o_req = r;
      o_retire = 1'h1;
      o_retire_in_delay = r.in_delay;
      o_retire_is_branch = r.is_branch;
      @(negedge i_clk_sys);
      o_req = '{pc: ~r.pc, branch_pc: ~r.branch_pc, default: '0};
      o_retire = 1'h0;
      o_retire_in_delay = ~r.in_delay;
   endtask : issue

   // Event 0 return, 1 nmi, 2 tlb fault, 3 bus error
   task pulse(input int k);
      @(negedge i_clk_sys);
      o_event = 4'h1 << k;
      @(negedge i_clk_sys);
      o_event = 4'h0;
   endtask : pulse
endmodule : pipeline_model

// ### test_debug_exception_unit.sv
`timescale 1ns/10ps
module test_debug_exception_unit;
   localparam logic [31:0]     MASK = 32'hFFFF_DFC3;
   localparam logic [4:0]      DCS  = debug_exc_pkg::REG_DEBUG_CONTROL_STATUS;
   localparam logic [4:0]      RET  = debug_exc_pkg::REG_DEBUG_RETURN_ADDRESS;
   logic                       i_clk_sys;
   logic                       i_sys_rst;
   debug_exc_pkg::debug_req_t  req;
   debug_exc_pkg::debug_req_t  r;
   debug_exc_pkg::reg_access_t reg_acc;
   logic                       retire;
   logic                       retire_in_delay;
   logic                       retire_is_branch;
   logic [3:0]                 ev;
   logic                       cache_autolock;
   logic                       redirect;
   logic [31:0]                redirect_pc;
   logic                       set_status;
   logic                       ord_update;
   logic                       nmi_take;
   logic                       ls_squash;
   logic                       autolock_en;
   logic                       step_active;
   logic [31:0]                reg_rdata;
   logic [4:0]                 seen;
   logic [31:0]                seen_pc;
   logic [31:0]                rd;
   logic [31:0]                bits;
   logic [31:0]                target;
   logic                       st, bp, coincident_nmi_flag, coincident_other_exc_flag;
   int                         n_fail = 0;
   int                         comparisons = 0;
   int                         seed = 32'h0EF8;

   initial begin
      i_clk_sys = 1'h0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end

   pipeline_model pipe (.i_clk_sys(i_clk_sys), .o_req(req), .o_retire(retire), .o_retire_in_delay(retire_in_delay),
                        .o_retire_is_branch(retire_is_branch), .o_event(ev));

   debug_exception_unit DUT (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_req(req), .i_retire(retire),
      .i_retire_in_delay(retire_in_delay), .i_retire_is_branch(retire_is_branch), .i_return_instr(ev[0]),
      .i_nmi_req(ev[1]), .i_ls_tlb_exc(ev[2]), .i_ls_bus_err(ev[3]), .i_cache_autolock(cache_autolock),
      .i_reg(reg_acc), .o_redirect(redirect), .o_redirect_pc(redirect_pc), .o_set_status_ku_ie(set_status),
      .o_ordinary_exc_update(ord_update), .o_nmi_take(nmi_take), .o_ls_squash(ls_squash),
      .o_autolock_en(autolock_en), .o_step_active(step_active), .o_reg_rdata(reg_rdata));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // Collect pulses: redirect, status set, ordinary update, nmi take, squash
   task run3;
      seen = {redirect, set_status, ord_update, nmi_take, ls_squash};
      seen_pc = redirect ? redirect_pc : 32'h0;
      repeat (3) begin
         @(negedge i_clk_sys);
         seen |= {redirect, set_status, ord_update, nmi_take, ls_squash};
         if (redirect) seen_pc = redirect_pc;
      end
   endtask : run3

   task rd_reg(input logic [4:0] a, output logic [31:0] d);
      @(negedge i_clk_sys);
      reg_acc.wr = 1'h0;
      reg_acc.addr = a;
      repeat (2) @(negedge i_clk_sys);
      d = reg_rdata;
   endtask : rd_reg

   task wr_reg(input logic [4:0] a, input logic [31:0] d);
      @(negedge i_clk_sys);
      reg_acc = '{wr: 1'h1, addr: a, wdata: d};
      @(negedge i_clk_sys);
      reg_acc.wr = 1'h0;
   endtask : wr_reg

   function automatic logic [31:0] dcs(input logic bd, dm, ni, oe, tl, bs, ss, b, s);
      dcs = 32'h0;
      dcs[debug_exc_pkg::BIT_BRANCH_DELAY] = bd;
      dcs[debug_exc_pkg::BIT_DEBUG_MODE] = dm;
      dcs[debug_exc_pkg::BIT_COINC_NMI] = ni;
      dcs[debug_exc_pkg::BIT_COINC_OTHER] = oe;
      dcs[debug_exc_pkg::BIT_TLB_EXC] = tl;
      dcs[debug_exc_pkg::BIT_BUS_ERROR] = bs;
      dcs[debug_exc_pkg::BIT_SINGLE_STEP] = ss;
      dcs[debug_exc_pkg::BIT_BREAKPOINT] = b;
      dcs[debug_exc_pkg::BIT_STEP_EXC] = s;
   endfunction : dcs

   task give_verdict;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict

   initial begin
      #200000;
      n_fail++;
      give_verdict();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      i_sys_rst = 1'h1;
      cache_autolock = 1'h0;
      reg_acc = '0;
      repeat (10) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      i_sys_rst = 1'h0;
      rd_reg(DCS, rd);
      check("dcs_reset", 32'h0, rd & MASK);
      rd_reg(RET, rd);
      check("ret_reset", debug_exc_pkg::RETURN_ADDR_RESET, rd);
      wr_reg(DCS, 32'hFFFF_FFFF);
      rd_reg(DCS, rd);
      check("dcs_write_ones", dcs(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0), rd & MASK);
      check("step_active", 32'h1, 32'(step_active));
      for (int i = 0; i < 40; i++) begin
         bits = $random(seed);
         r = '0;
         r.pc = $random(seed) & 32'hFFFF_FFFC;
         r.branch_pc = r.pc - 32'h4;
         r.brk = (bits[1:0] != 2'h1);
         r.step = (bits[1:0] != 2'h0);
         r.in_delay = bits[2];
         r.nmi = bits[3] & bits[8];
         r.other_exc = bits[4];
         st = r.step && !r.in_delay;
         bp = r.brk && !st;
         coincident_nmi_flag = r.nmi;
         coincident_other_exc_flag = r.other_exc && !r.nmi;
         cache_autolock = bits[5];
         pipe.issue(r);
         run3();
         check("entry_pulses", 32'({st | bp, 1'h0, (st | bp) & (coincident_nmi_flag | coincident_other_exc_flag), 2'h0}), 32'(seen));
         if (!(st | bp)) continue;
         check("entry_pc", debug_exc_pkg::DEBUG_VECTOR, seen_pc);
         check("step_forced_off", 32'h0, 32'(step_active));
         check("autolock_off", 32'h0, 32'(autolock_en));
         rd_reg(RET, rd);
         check("ret_addr", r.in_delay ? r.branch_pc : r.pc, rd);
         r.brk = 1'h1;
         pipe.issue(r);
         run3();
         check("nested_break", 32'h0, 32'(seen));
         for (int k = 1; k < 4; k++) begin
            pipe.pulse(k);
            run3();
            check("handler_event", (k == 2) ? 32'h1 : 32'h0, 32'(seen));
         end
         rd_reg(DCS, rd);
         check("dcs_entry", dcs(r.in_delay, 1'h1, coincident_nmi_flag, coincident_other_exc_flag, 1'h1, 1'h1, 1'h1, bp, st), rd & MASK);
         wr_reg(DCS, 32'h0000_0100);
         rd_reg(DCS, rd);
         check("bus_err_clear", dcs(r.in_delay, 1'h1, coincident_nmi_flag, coincident_other_exc_flag, 1'h1, 1'h0, 1'h1, bp, st), rd & MASK);
         target = r.in_delay ? r.branch_pc : r.pc;
         if (coincident_nmi_flag) target = 32'hBFC0_0000;
         else if (coincident_other_exc_flag) target = bits[6] ? 32'hBFC0_0180 : 32'h8000_0080;
         if (coincident_nmi_flag | coincident_other_exc_flag) wr_reg(RET, target);
         pipe.pulse(0);
         run3();
         check("return_pulses", 32'h1A, 32'(seen));
         check("return_pc", target, seen_pc);
         check("step_back_on", 32'h1, 32'(step_active));
         check("autolock_back", 32'(bits[5]), 32'(autolock_en));
         r = '0;
         r.step = 1'h1;
         r.pc = target;
         pipe.issue(r);
         run3();
         check("return_target_exempt", 32'h0, 32'(seen));
      end
      wr_reg(DCS, 32'h0);
      r = '0;
      r.step = 1'h1;
      pipe.issue(r);
      run3();
      check("step_disabled", 32'h0, 32'(seen));
      r = '0;
      r.brk = 1'h1;
      pipe.issue(r);
      i_sys_rst = 1'h1;
      repeat (2) @(negedge i_clk_sys);
      i_sys_rst = 1'h0;
      rd_reg(DCS, rd);
      check("dcs_reset_in_handler", 32'h0, rd & MASK);
      give_verdict();
   end
endmodule : test_debug_exception_unit
